// [hw/sysctl_pkg.sv]
package sysctl_pkg;
  localparam logic [7:0]  SYSCTL_ADDR_ONE      = 8'h03;
  localparam logic [7:0]  SYSCTL_ADDR_TWO      = 8'h04;
  // system control one field positions
  localparam int          ONE_CHIP_ON          = 15;
  localparam int          ONE_SYS_REBOOT       = 14;
  localparam int          ONE_POWER_CYCLE      = 13;
  localparam int          ONE_FAULT_OV         = 12;
  localparam int          ONE_HOLD_LSB         = 10;
  localparam int          ONE_BANDGAP          = 9;
  localparam int          ONE_WDOG_HALT        = 7;
  localparam int          ONE_CHIP_RST_EN      = 6;
  localparam int          ONE_MEM_VALID        = 5;
  localparam int          ONE_CONFIGURED       = 4;
  localparam int          ONE_KEY_DEB          = 3;
  localparam int          ONE_KEY_POL          = 1;
  localparam int          ONE_INTERRUPT_PIN_POLARITY          = 0;
  // system control two field positions
  localparam int          TWO_LOW_SUSPEND      = 15;
  localparam int          TWO_SUSPEND          = 14;
  localparam int          TWO_ROLE             = 13;
  localparam int          TWO_SUPPLY_SEL       = 12;
  localparam int          TWO_HOST_CUR         = 11;
  localparam int          TWO_LIMIT_BYPASS     = 10;
  localparam int          TWO_DEV_CUR          = 9;
  localparam int          TWO_WDOG_HIB         = 7;
  localparam int          TWO_WATCHDOG_MODE_FIELD_LSB    = 4;
  localparam int          TWO_WDOG_TO_LSB      = 0;
  // implemented bits; others read zero
  localparam logic [15:0] ONE_MASK             = 16'hfefb;
  localparam logic [15:0] TWO_MASK             = 16'hfeb7;
  // bits guarded by the security key
  localparam logic [15:0] ONE_KEY_MASK         = 16'h408a;
  localparam logic [15:0] TWO_KEY_MASK         = 16'h0037;
  // values after reset
  localparam logic [15:0] ONE_RESET            = 16'h1c02;
  localparam logic [15:0] TWO_RESET            = 16'h0004;
  // hold times in ms, debounce in s
  localparam int          CLK_HZ               = 100_000_000;
  localparam int          HOLD_MS_BASE         = 15;
  localparam int          DEB_LONG_S           = 10;
  localparam int          DEB_SHORT_S          = 5;
  localparam longint      HOLD_BASE_CYCLES     = longint'(HOLD_MS_BASE) * CLK_HZ / 1000;
  localparam longint      DEB_LONG_CYCLES      = longint'(DEB_LONG_S) * CLK_HZ;
  localparam longint      DEB_SHORT_CYCLES     = longint'(DEB_SHORT_S) * CLK_HZ;
  typedef enum logic [1:0] {
    WDOG_OFF       = 2'h0,
    WDOG_IRQ       = 2'h1,
    WDOG_IRQ_RESET = 2'h2,
    WDOG_TWO_STAGE = 2'h3
  } sysctl_watchdog_mode_field_type;
  typedef enum logic [1:0] {
    HOLD_IDLE = 2'h1,
    HOLD_LOW  = 2'h2
  } sysctl_hold_state_type;
endpackage

// [hw/sysctl_regs.sv]
// Contract
// - hold reset outputs low for selected time
// - bandgap never sleeps unless bit set
// - debug bit halts watchdog counting
// - memory-valid cleared at startup, memory reset
// - configured flag cleared only by power-on; code also clears it on a register one write with chip-on set and that bit zero
// - power key debounce ten or five seconds
// - key polarity bit selects active level
// - interrupt pin polarity selected by bit
// - low-current suspend bit suspends with 8mA
// - suspend bit opens USB power switch
// - suspend and slave current cleared on faults
// - role bit selects USB slave or master
// - role cleared on master-to-slave transition
// - source bit picks buck output or wall; code applies it only in master role, usbFromWall stays low in slave role
// - host-mode current limit 100 or 500mA
// - bypass bit disables USB current limiting
// - device-mode current limit 100 or 500mA
// - hibernate watchdog disabled unless keep bit
// - key-protected bits writable only when unlocked
// - state machine reset restores mask defaults
// - writing chip-on zero powers chip down
// - watchdog mode field selects time-out action
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs
  import sysctl_pkg::*;
#(
  parameter longint HOLD_BASE = sysctl_pkg::HOLD_BASE_CYCLES,
  parameter longint DEB_LONG  = sysctl_pkg::DEB_LONG_CYCLES,
  parameter longint DEB_SHORT = sysctl_pkg::DEB_SHORT_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        regWrite,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  input  wire logic        securityUnlocked,
  input  wire logic        smReset,
  input  wire logic        memResetAssert,
  input  wire logic        activeEntry,
  input  wire logic        hibernate,
  input  wire logic        lineUvlo,
  input  wire logic        bootHystFail,
  input  wire logic        usbMasterToSlave,
  input  wire logic        powerKeyPin,
  input  wire logic        irqRequest,
  output logic             irqPin,
  output logic             cpuReset_b,
  output logic             memory_reset_out_b,
  output logic             bandgapSleepAllowed,
  output logic             watchdogRun,
  output logic [1:0]       watchdogMode,
  output logic             chipPowerDown,
  output logic             powerKeyShutdown,
  output logic             usbSwitchOpen,
  output logic             usbSuspendLow,
  output logic             usbMaster,
  output logic             usbFromWall,
  output logic             usbLimit500,
  output logic             usbLimitOff
);
  import sysctl_pkg::*;

  logic [15:0] oneReg;
  logic [15:0] twoReg;
  logic [15:0] oneNext;
  logic [15:0] twoNext;
  logic [15:0] oneWmask;
  logic [15:0] twoWmask;
  logic        wrOne;
  logic        wrTwo;
  logic        keyMeta;
  logic        keySync;
  logic        irqOutReg;
  logic        keyDebReg;
  logic [39:0] debCountReg;
  logic [31:0] holdCountReg;
  logic [31:0] holdLimit;
  logic        sysRebootPulse;
  sysctl_hold_state_type holdStateReg;

  ////////////////////////////////////////////////////////////////////////////
  assign wrOne = regWrite && (regAddr == SYSCTL_ADDR_ONE);
  assign wrTwo = regWrite && (regAddr == SYSCTL_ADDR_TWO);
  // locked key drops guarded bits from the write
  assign oneWmask = ONE_MASK & ~(securityUnlocked ? 16'h0000 : ONE_KEY_MASK);
  assign twoWmask = TWO_MASK & ~(securityUnlocked ? 16'h0000 : TWO_KEY_MASK);

  always_comb begin
    oneNext = oneReg;
    if (wrOne) begin
      oneNext = (oneReg & ~oneWmask) | (regWdata & oneWmask);
    end
    // reboot request is a one-shot, never stored
    oneNext[ONE_SYS_REBOOT] = 1'b0;
    if (smReset || (wrOne && !regWdata[ONE_CHIP_ON])) begin
      // state machine reset: mask defaults, configured flag survives
      oneNext = (ONE_RESET & ~(16'h1 << ONE_CONFIGURED)) | (oneReg & (16'h1 << ONE_CONFIGURED));
      oneNext[ONE_KEY_DEB] = oneReg[ONE_KEY_DEB];
      oneNext[ONE_BANDGAP] = oneReg[ONE_BANDGAP];
      oneNext[ONE_WDOG_HALT] = oneReg[ONE_WDOG_HALT];
      oneNext[ONE_POWER_CYCLE] = oneReg[ONE_POWER_CYCLE];
      // memory stays valid unless the memory reset itself fires
      oneNext[ONE_MEM_VALID] = oneReg[ONE_MEM_VALID];
    end
    if (memResetAssert) begin
      oneNext[ONE_MEM_VALID] = 1'b0;
    end
  end

  always_comb begin
    twoNext = twoReg;
    if (wrTwo) begin
      twoNext = (twoReg & ~twoWmask) | (regWdata & twoWmask);
    end
    if (usbMasterToSlave) begin
      twoNext[TWO_ROLE] = 1'b0;
    end
    if (smReset || (wrOne && !regWdata[ONE_CHIP_ON])) begin
      twoNext[TWO_ROLE] = TWO_RESET[TWO_ROLE];
      twoNext[TWO_SUPPLY_SEL] = TWO_RESET[TWO_SUPPLY_SEL];
      twoNext[TWO_HOST_CUR] = TWO_RESET[TWO_HOST_CUR];
      twoNext[TWO_DEV_CUR] = TWO_RESET[TWO_DEV_CUR];
      twoNext[TWO_WATCHDOG_MODE_FIELD_LSB +: 2] = TWO_RESET[TWO_WATCHDOG_MODE_FIELD_LSB +: 2];
    end
    if (smReset || lineUvlo || bootHystFail) begin
      twoNext[TWO_LOW_SUSPEND] = 1'b0;
      twoNext[TWO_SUSPEND] = 1'b0;
      twoNext[TWO_DEV_CUR] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oneReg <= ONE_RESET;
    end else begin
      oneReg <= oneNext;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      twoReg <= TWO_RESET;
    end else begin
      twoReg <= twoNext;
    end
  end

  assign sysRebootPulse = wrOne && regWdata[ONE_SYS_REBOOT] && securityUnlocked;

  always_comb begin
    case (regAddr)
      SYSCTL_ADDR_ONE: regRdata = oneReg & ONE_MASK;
      SYSCTL_ADDR_TWO: regRdata = twoReg & TWO_MASK;
      default:         regRdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset hold: base time doubled per code step
  assign holdLimit = 32'(HOLD_BASE << oneReg[ONE_HOLD_LSB +: 2]);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      holdStateReg <= HOLD_IDLE;
      holdCountReg <= 32'h0;
    end else begin
      case (holdStateReg)
        HOLD_IDLE: begin
          if (activeEntry || sysRebootPulse) begin
            holdStateReg <= HOLD_LOW;
            holdCountReg <= 32'h0;
          end
        end
        HOLD_LOW: begin
          if (holdCountReg >= holdLimit - 32'h1) begin
            holdStateReg <= HOLD_IDLE;
          end else begin
            holdCountReg <= holdCountReg + 32'h1;
          end
        end
        default: holdStateReg <= HOLD_IDLE;
      endcase
    end
  end

  assign cpuReset_b = (holdStateReg != HOLD_LOW);
  assign memory_reset_out_b = (holdStateReg != HOLD_LOW) && !memResetAssert;

  ////////////////////////////////////////////////////////////////////////////
  // pin comes from outside, two flops before use
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // idle level of the default active-low key, no false press
      keyMeta <= 1'b1;
      keySync <= 1'b1;
    end else begin
      keyMeta <= powerKeyPin;
      keySync <= keyMeta;
    end
  end

  // pressed level depends on polarity bit
  assign keyDebReg = keySync ^ oneReg[ONE_KEY_POL];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      debCountReg <= 40'h0;
      powerKeyShutdown <= 1'b0;
    end else if (!keyDebReg) begin
      debCountReg <= 40'h0;
      powerKeyShutdown <= 1'b0;
    end else if (debCountReg >= 40'(oneReg[ONE_KEY_DEB] ? DEB_SHORT : DEB_LONG) - 40'h1) begin
      powerKeyShutdown <= 1'b1;
    end else begin
      debCountReg <= debCountReg + 40'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqOutReg <= 1'b1;
    end else begin
      irqOutReg <= irqRequest ~^ oneReg[ONE_INTERRUPT_PIN_POLARITY];
    end
  end
  assign irqPin = irqOutReg;

  assign bandgapSleepAllowed = oneReg[ONE_BANDGAP];
  assign watchdogMode = (hibernate && !twoReg[TWO_WDOG_HIB]) ? WDOG_OFF
                        : twoReg[TWO_WATCHDOG_MODE_FIELD_LSB +: 2];
  // halted counter keeps its value, no reload
  assign watchdogRun = (watchdogMode != WDOG_OFF) && !oneReg[ONE_WDOG_HALT];
  assign chipPowerDown = !oneReg[ONE_CHIP_ON];

  assign usbSuspendLow = twoReg[TWO_LOW_SUSPEND];
  assign usbSwitchOpen = twoReg[TWO_SUSPEND] | twoReg[TWO_LOW_SUSPEND];
  assign usbMaster = twoReg[TWO_ROLE];
  assign usbFromWall = twoReg[TWO_ROLE] & twoReg[TWO_SUPPLY_SEL];
  assign usbLimit500 = twoReg[TWO_ROLE] ? twoReg[TWO_HOST_CUR] : twoReg[TWO_DEV_CUR];
  assign usbLimitOff = twoReg[TWO_LIMIT_BYPASS];
endmodule
`default_nettype wire

// [test/sysctl_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs_monitor
  import sysctl_pkg::*;
#(
  parameter longint HOLD_BASE = 4
) (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        regWrite,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        securityUnlocked,
  input wire logic        smReset,
  input wire logic        memResetAssert,
  input wire logic        lineUvlo,
  input wire logic        bootHystFail,
  input wire logic        usbMasterToSlave,
  input wire logic        irqRequest,
  input wire logic        irqPin,
  input wire logic        cpuReset_b,
  input wire logic        bandgapSleepAllowed,
  input wire logic        usbSwitchOpen,
  input wire logic        usbSuspendLow,
  input wire logic        usbMaster,
  input wire logic        usbFromWall,
  input wire logic        usbLimitOff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] lowCnt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt <= 32'h0;
    end else begin
      lowCnt <= cpuReset_b ? 32'h0 : lowCnt + 32'h1;
    end
  end
  ////////////////////////////////////////
  sequence s_lockedOne;
    regWrite && !securityUnlocked && !smReset && regWdata[15] && regAddr == SYSCTL_ADDR_ONE
      ##1 regAddr == SYSCTL_ADDR_ONE;
  endsequence
  property p_lock;
    s_lockedOne |-> ((regRdata ^ $past(regRdata)) & ONE_KEY_MASK) == 16'h0;
  endproperty
  property p_role;
    regWrite && regAddr == SYSCTL_ADDR_TWO && !smReset && !usbMasterToSlave |=>
      usbMaster == |($past(regWdata) & 16'h2000);
  endproperty
  property p_m2s;
    usbMasterToSlave |=> !usbMaster;
  endproperty
  property p_fault;
    lineUvlo || bootHystFail |=> !usbSwitchOpen && !usbSuspendLow;
  endproperty
  property p_susp;
    regAddr == SYSCTL_ADDR_TWO |-> usbSuspendLow == regRdata[15] && usbSwitchOpen == (regRdata[15] | regRdata[14]);
  endproperty
  property p_two;
    regAddr == SYSCTL_ADDR_TWO |->
      {usbMaster, usbFromWall, usbLimitOff} == {regRdata[13], regRdata[13] & regRdata[12], regRdata[10]};
  endproperty
  property p_bg;
    regAddr == SYSCTL_ADDR_ONE |-> bandgapSleepAllowed == regRdata[9];
  endproperty
  property p_undef;
    (regRdata & ~(regAddr == SYSCTL_ADDR_ONE ? ONE_MASK : regAddr == SYSCTL_ADDR_TWO ? TWO_MASK : 16'h0)) == 16'h0;
  endproperty
  property p_mem;
    memResetAssert ##1 regAddr == SYSCTL_ADDR_ONE |-> !regRdata[5];
  endproperty
  // shortest hold is the base count, whatever the select
  property p_hold;
    $rose(cpuReset_b) |-> lowCnt >= HOLD_BASE;
  endproperty
  property p_irq;
    $past(rst_b) && regAddr == SYSCTL_ADDR_ONE && $past(regAddr) == SYSCTL_ADDR_ONE && $stable(regRdata) |->
      irqPin == ($past(irqRequest) ~^ regRdata[0]);
  endproperty
  a_lock: assert property (p_lock) else $error("guarded bit changed while locked");
  a_role: assert property (p_role) else $error("role bit not written");
  a_m2s: assert property (p_m2s) else $error("role not cleared");
  a_fault: assert property (p_fault) else $error("suspend not cleared on fault");
  a_susp: assert property (p_susp) else $error("suspend outputs wrong");
  a_two: assert property (p_two) else $error("usb outputs wrong");
  a_bg: assert property (p_bg) else $error("bandgap output wrong");
  a_undef: assert property (p_undef) else $error("undefined bit set");
  a_mem: assert property (p_mem) else $error("memory valid kept");
  a_hold: assert property (p_hold) else $error("hold too short");
  a_irq: assert property (p_irq) else $error("irq pin polarity wrong");
endmodule
bind sysctl_regs sysctl_regs_monitor #(.HOLD_BASE(HOLD_BASE)) sysctl_regs_monitor_i (.*);
`default_nettype wire

// [test/sysctl_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sysctl_host_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] regRdata,
  output logic             regWrite,
  output logic [7:0]       regAddr,
  output logic [15:0]      regWdata,
  output logic             securityUnlocked
);
  initial begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    securityUnlocked = 1'b0;
  end
  // data flipped after the strobe so a stale word never looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge core_clk);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk);
    regAddr = a;
    @(negedge core_clk);
    d = regRdata;
  endtask
  task automatic key(input logic u);
    @(negedge core_clk);
    securityUnlocked = u;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sysctl_pkg::*;
  localparam longint HB = 4;
  localparam longint DL = 40;
  localparam longint DS = 20;
  localparam logic [7:0] A1 = SYSCTL_ADDR_ONE;
  localparam logic [7:0] A2 = SYSCTL_ADDR_TWO;
  logic        core_clk = 1'b0, rst_b = 1'b0, irqRequest = 1'b0, powerKeyPin = 1'b1, hibernate = 1'b0;
  logic        smReset = 1'b0, memResetAssert = 1'b0, activeEntry = 1'b0, lineUvlo = 1'b0;
  logic        bootHystFail = 1'b0, usbMasterToSlave = 1'b0, regWrite, securityUnlocked, irqPin;
  logic        cpuReset_b, memory_reset_out_b, bandgapSleepAllowed, watchdogRun, chipPowerDown;
  logic        powerKeyShutdown, usbSwitchOpen, usbSuspendLow, usbMaster, usbFromWall, usbLimit500, usbLimitOff;
  logic [1:0]  watchdogMode;
  logic [7:0]  regAddr;
  logic [15:0] regWdata, regRdata, rv;
  int          errors = 0, compares = 0, n, m;
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) irqRequest <= ~irqRequest;
  sysctl_regs #(.HOLD_BASE(HB), .DEB_LONG(DL), .DEB_SHORT(DS)) sysctl_regs_i (.*);
  sysctl_host_model sysctl_host_model_i (.*);
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    sysctl_host_model_i.wr(a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    sysctl_host_model_i.rd(a, rv);
    check(rv, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic doReset;
    rst_b = 1'b0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
  endtask
  ////////////////////////////////////////
  initial begin
    doReset();
    rdchk(A1, 16'h1c02);
    rdchk(A2, 16'h0004);
    rdchk(8'h05, 16'h0000);
    wr(A1, 16'hffff);
    rdchk(A1, 16'hbe73);
    sysctl_host_model_i.key(1'b1);
    wr(A2, 16'hfeb4);
    rdchk(A2, 16'hfeb4);
    check(16'({usbSwitchOpen, usbSuspendLow, usbMaster, usbFromWall, usbLimitOff}), 16'h1f);
    check(16'({usbLimit500, chipPowerDown}), 16'h2);
    check(16'(watchdogRun), 16'h1);
    wr(A1, 16'hbef3);
    check(16'(watchdogRun), 16'h0);
    hibernate = 1'b1;
    @(negedge core_clk);
    check(16'(watchdogMode), 16'h3);
    wr(A2, 16'hfe34);
    check(16'(watchdogMode), 16'h0);
    hibernate = 1'b0;
    for (int f = 0; f < 2; f++) begin
      wr(A2, 16'hfeb4);
      if (f == 0) pulse(lineUvlo);
      else pulse(bootHystFail);
      rdchk(A2, 16'h3cb4);
    end
    pulse(usbMasterToSlave);
    rdchk(A2, 16'h1cb4);
    check(16'({usbMaster, usbFromWall, usbLimit500}), 16'h0);
    pulse(smReset);
    sysctl_host_model_i.rd(A2, rv);
    check(rv & 16'h3800, 16'h0);
    rdchk(A1, 16'h3eb2);
    pulse(memResetAssert);
    rdchk(A1, 16'h3e92);
    doReset();
    rdchk(A1, 16'h1c02);
    for (int s = 0; s < 4; s++) begin
      wr(A1, 16'h8002 | 16'(s << 10));
      pulse(activeEntry);
      // hold already started at the edge that took the pulse
      n = int'(cpuReset_b === 1'b0);
      m = int'(memory_reset_out_b === 1'b0);
      repeat (40) begin
        @(negedge core_clk);
        n += int'(cpuReset_b === 1'b0);
        m += int'(memory_reset_out_b === 1'b0);
      end
      check(16'(n), 16'(HB << s));
      check(16'(m), 16'(HB << s));
    end
    wr(A1, 16'h8003);
    wr(A1, 16'h0003);
    rdchk(A1, 16'h1c02);
    // third pass flips the key to active high
    for (int k = 0; k < 3; k++) begin
      powerKeyPin = (k < 2);
      doReset();
      wr(A1, 16'h8000 | (k > 0 ? 16'h0008 : 16'h0) | (k < 2 ? 16'h0002 : 16'h0));
      powerKeyPin = (k == 2);
      n = 0;
      while (powerKeyShutdown !== 1'b1 && n < 200) begin
        @(negedge core_clk);
        n++;
      end
      if (n >= 200) begin
        errors++;
        final_report();
      end
      check(16'(n >= (k > 0 ? DS : DL) && n <= (k > 0 ? DS : DL) + 4), 16'h1);
    end
    final_report();
  end
endmodule
`default_nettype wire
